/* File: bench/cmpc_core_model.sv */
// Behavioural analog comparator core with its two input multiplexers
`timescale 1ns/1ps
`default_nettype none

module cmpc_core_model
	import cmpc_pkg::*;
(
	input  wire logic        clk_i,      // Block clock
	input  wire logic        en_i,       // Core power
	input  wire cmpc_route_t route_i,    // Mux selections
	input  wire logic [7:0]  volt_i [6], // Pin a, reference, b, c, d, band-gap
	output logic             raw_o       // Core decision
);
	logic [7:0] pos; // Non-inverting level
	logic [7:0] neg; // Inverting level

	// ------------------------------------------------------------
	// Input multiplexers
	// ------------------------------------------------------------
	always_comb
	begin
		pos = route_i.positive_input_select ? volt_i[1] : volt_i[0];
		neg = volt_i[2 + route_i.negative_input_select];
	end

	// Unpowered the core output is junk, so it toggles to expose leaks;
	// an unknown start counts as low, so toggling begins at once
	always @(posedge clk_i)
		raw_o <= en_i ? (pos > neg) : (raw_o !== 1'b1);
endmodule

`default_nettype wire

/* File: bench/cmpc_top_tb.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none

module cmpc_top_tb;
	import cmpc_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk;       // 25 MHz clock
	logic        rst_n;     // Synchronous reset
	logic [7:0]  addr;      // Bus address
	logic [31:0] wdata;     // Bus write data
	logic        wr;        // Write strobe
	logic        rd;        // Read strobe
	logic [31:0] rdata;     // Bus read data
	logic        raw;       // Core decision
	logic        core_en;   // Core power
	cmpc_route_t route;     // Mux selections
	logic        pin;       // Result pin
	logic        pin_oe;    // Result pin enable
	logic        pulse;     // Event pulse
	logic        irq;       // Interrupt line
	logic [7:0]  volt [6];  // Analog levels
	logic [31:0] rnd;       // Random state
	logic [31:0] d;         // Written value
	logic [31:0] q;         // Read value
	logic        ev;        // Expected event
	int          bad_count; // Mismatches
	int          n_checks;  // Comparisons
	int          n_pulse;   // Pulses seen

	cmpc_top u_cmpc_top (.SYS_CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .CMP_RAW_I(raw), .CMP_ENABLE_O(core_en), .ROUTE_O(route),
		.RESULT_PIN_O(pin), .RESULT_PIN_OE_O(pin_oe), .EVENT_PULSE_O(pulse), .IRQ_O(irq));
	cmpc_core_model u_cmpc_core_model (.clk_i(clk), .en_i(core_en), .route_i(route), .volt_i(volt), .raw_o(raw));

	// ------------------------------------------------------------
	// Clock, pulse counter, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
		if (pulse === 1'b1)
			n_pulse++;
	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Event expected for one core edge; inversion swaps the edge seen
	function automatic logic ev_exp(input logic [1:0] e, input logic inv, input logic rise);
		return (rise ^ inv) ? e[0] : e[1];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_n, addr, wdata, wr, rd, bad_count, n_checks, n_pulse} = '0;
		volt = '{default: 8'h00};
		rnd = 32'h75bb0ab0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus_rd(CTRL_ADDR, q);
		chk(q, 32'h000000c3);
		chk(route, 3'h3);
		bus_rd(8'h10, q);
		chk(q, 32'h0);
		bus_wr(CTRL_ADDR, 32'hffffffff);
		repeat (6) @(posedge clk);
		bus_rd(CTRL_ADDR, q);
		chk(q, 32'h0000e1d3);
		chk(pin, 1'b1);
		// Random fields and levels; invert kept off so readback is plain
		for (int i = 0; i < 24; i++)
		begin
			rnd = lfsr(rnd);
			foreach (volt[k])
				volt[k] <= rnd[k * 4 +: 8];
			rnd = lfsr(rnd);
			d = {rnd[31:14], 1'b0, rnd[12:5], i[2], rnd[3:2], i[1:0]};
			bus_wr(CTRL_ADDR, d);
			// Idle cycles after setting enable keep software's duty
			repeat (6) @(posedge clk);
			ev = d[15] & ((d[4] ? volt[1] : volt[0]) > volt[2 + d[1:0]]);
			bus_rd(CTRL_ADDR, q);
			chk(q, (d & 32'h0000c0d3) | {23'h0, ev, 8'h0});
			chk(route, {d[4], d[1:0]});
			chk(pin_oe, d[14]);
			chk(pin, ev);
			chk(core_en, d[15]);
		end
		// Every edge mode with and without inversion, mask on when inverted
		volt[2] <= 8'h80;
		for (int m = 0; m < 8; m++)
		begin
			volt[0] <= 8'h10;
			bus_wr(IRQ_MASK_ADDR, {31'h0, m[2]});
			bus_wr(CTRL_ADDR, {16'h0, 2'h3, m[2], 5'h0, m[1:0], 6'h0});
			repeat (6) @(posedge clk);
			bus_rd(IRQ_STAT_ADDR, q);
			n_pulse = 0;
			for (int r = 1; r >= 0; r--)
			begin
				volt[0] <= r[0] ? 8'hf0 : 8'h10;
				repeat (6) @(posedge clk);
				#1 ev = ev_exp(m[1:0], m[2], r[0]);
				chk(32'(n_pulse), {31'h0, ev});
				chk(pin, r[0] ^ m[2]);
				chk(irq, ev & m[2]);
				bus_rd(IRQ_STAT_ADDR, q);
				chk(q, {31'h0, ev});
				chk(irq, 1'b0);
				n_pulse = 0;
			end
		end
		stop_test();
	end
endmodule

`default_nettype wire

/* File: hw/cmpc_pkg.sv */
// Package for the comparator control block: register map, fields, structs
package cmpc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_ADDR    = 8'h00; // Control register
	localparam logic [7:0]  IRQ_STAT_ADDR = 8'h04; // Sticky event status
	localparam logic [7:0]  IRQ_MASK_ADDR = 8'h08; // Event mask

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int BIT_ENABLE  = 15;
	localparam int BIT_DRIVE   = 14;
	localparam int BIT_INVERT  = 13;
	localparam int BIT_RESULT  = 8;
	localparam int BIT_EDGE_HI = 7;
	localparam int BIT_EDGE_LO = 6;
	localparam int BIT_POSSEL  = 4;
	localparam int BIT_NEG_HI  = 1;
	localparam int BIT_NEG_LO  = 0;

	// Edge event selections
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Negative input selections
	localparam logic [1:0] NEG_PIN_B   = 2'h0;
	localparam logic [1:0] NEG_PIN_C   = 2'h1;
	localparam logic [1:0] NEG_PIN_D   = 2'h2;
	localparam logic [1:0] NEG_BANDGAP = 2'h3;

	// Reset values of the writable fields
	localparam logic       RST_ENABLE = 1'h0;
	localparam logic       RST_DRIVE  = 1'h0;
	localparam logic       RST_INVERT = 1'h0;
	localparam logic [1:0] RST_EDGE   = 2'h3;
	localparam logic       RST_POSSEL = 1'h0;
	localparam logic [1:0] RST_NEG    = 2'h3;
	localparam logic       RST_IRQ    = 1'h0;

	// Writable control fields
	typedef struct packed {
		logic       enable;     // Module on
		logic       pin_drive_enable;
		logic       result_invert;
		logic [1:0] edge_event_select;
		logic       positive_input_select;
		logic [1:0] negative_input_select;
	} cmpc_ctrl_t;

	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cmpc_bus_t;

	// Analog mux routing to the comparator core
	typedef struct packed {
		logic       positive_input_select; // 1: reference voltage
		logic [1:0] negative_input_select;
	} cmpc_route_t;

endpackage

/* File: hw/cmpc_top.sv */
// Comparator control, readback, input routing and edge event logic
//
// Functional notes
// - Bit 15 enables module, others untouched
// - Bit 14 drives result onto pin
// - Bit 13 inverts comparator output
// - Bit 8 reads back comparator result
// - Edge select 11: interrupt both edges
// - Edge select 10: falling edge only
// - Edge select 01: rising edge only
// - Edge select 00: never interrupt
// - Inversion also feeds the edge detector
// - Bit 4 picks reference or pin A
// - Bits 1-0 pick B, C, D, band-gap
// - Unused bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none

module cmpc_top
(
	input  wire logic                 SYS_CLK_I,      // 25 MHz clock
	input  wire logic                 RSTN_I,         // Synchronous reset, low
	input  wire logic [7:0]           ADDR_I,         // Register address
	input  wire logic [31:0]          WDATA_I,        // Write data
	input  wire logic                 WR_I,           // Write strobe
	input  wire logic                 RD_I,           // Read strobe
	output logic      [31:0]          RDATA_O,        // Read data, cycle after strobe
	input  wire logic                 CMP_RAW_I,      // Raw comparator core output
	output logic                      CMP_ENABLE_O,   // Power the analog core
	output cmpc_pkg::cmpc_route_t     ROUTE_O,        // Input mux selections
	output logic                      RESULT_PIN_O,   // Result output pin level
	output logic                      RESULT_PIN_OE_O,// Result output pin enable
	output logic                      EVENT_PULSE_O,  // One-cycle event request
	output logic                      IRQ_O           // Level interrupt
);
	import cmpc_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Bus request and control fields
	cmpc_bus_t  bus;             // Bundled request
	cmpc_ctrl_t ctrl;            // Control fields
	cmpc_ctrl_t next_ctrl;
	// Synchroniser, history and edge detector
	logic       sync_a;          // First synchroniser stage
	logic       sync_b;          // Second synchroniser stage
	logic       prev_b;          // Previous sample for edges
	logic       next_sync_a;
	logic       next_sync_b;
	logic       next_prev_b;
	logic       result;          // Inverted-or-not result
	logic       prev_result;     // Previous result
	logic       rise;            // Rising edge of result
	logic       fall;            // Falling edge of result
	logic       edge_hit;        // Qualifying edge
	// Event pulse, status, mask and read path
	logic       event_pulse;     // Registered event
	logic       next_event_pulse;
	logic       irq_stat;        // Sticky status
	logic       irq_mask;        // Mask, 1 enables
	logic       next_irq_stat;
	logic       next_irq_mask;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [31:0] ctrl_word;      // Control register image

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------

	// Field-wise write; unused bits simply have no storage
	always_comb
	begin
		next_ctrl = ctrl;
		if (bus.wr && bus.addr == CTRL_ADDR)
		begin
			// Each field is written independently of the enable bit
			next_ctrl.enable                = bus.wdata[BIT_ENABLE];
			next_ctrl.pin_drive_enable      = bus.wdata[BIT_DRIVE];
			next_ctrl.result_invert         = bus.wdata[BIT_INVERT];
			next_ctrl.edge_event_select     = bus.wdata[BIT_EDGE_HI:BIT_EDGE_LO];
			next_ctrl.positive_input_select = bus.wdata[BIT_POSSEL];
			next_ctrl.negative_input_select = bus.wdata[BIT_NEG_HI:BIT_NEG_LO];
		end
	end

	// Register the control fields
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			// Defaults: off, edge and negative select fields all ones, positive select zero
			ctrl <= '{enable: RST_ENABLE, pin_drive_enable: RST_DRIVE,
				result_invert: RST_INVERT, edge_event_select: RST_EDGE,
				positive_input_select: RST_POSSEL, negative_input_select: RST_NEG};
		end
		else
		begin
			ctrl <= next_ctrl;
		end
	end

	// ------------------------------------------------------------
	// Result synchroniser and edge detection
	// ------------------------------------------------------------

	// Two-stage synchroniser, then a history sample
	// Only the second stage and the history sample feed logic; the first may settle late
	always_comb
	begin
		next_sync_a = CMP_RAW_I;
		next_sync_b = sync_a;
		next_prev_b = sync_b;
	end

	// Synchroniser flops; reset to low
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			sync_a <= 1'h0;
			sync_b <= 1'h0;
			prev_b <= 1'h0;
		end
		else
		begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			prev_b <= next_prev_b;
		end
	end

	// Inversion sits ahead of both pin and edge detector
	// A disabled core reads low, so no edges come while off
	assign result      = (sync_b & ctrl.enable) ^ ctrl.result_invert;
	assign prev_result = (prev_b & ctrl.enable) ^ ctrl.result_invert;
	assign rise        = result & ~prev_result;
	assign fall        = ~result & prev_result;

	// Edge qualification by the selected polarity
	// Both-edge mode is simply the OR of the two detectors
	always_comb
	begin
		unique case (ctrl.edge_event_select)
			EDGE_NONE: edge_hit = 1'h0;
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			EDGE_BOTH: edge_hit = rise | fall;
		endcase
	end

	// ------------------------------------------------------------
	// Event status, mask and read data
	// ------------------------------------------------------------

	// Control image; unimplemented bits forced to zero
	always_comb
	begin
		ctrl_word                         = 32'h0;
		ctrl_word[BIT_ENABLE]             = ctrl.enable;
		ctrl_word[BIT_DRIVE]              = ctrl.pin_drive_enable;
		ctrl_word[BIT_INVERT]             = ctrl.result_invert;
		ctrl_word[BIT_RESULT]             = result;
		ctrl_word[BIT_EDGE_HI:BIT_EDGE_LO] = ctrl.edge_event_select;
		ctrl_word[BIT_POSSEL]             = ctrl.positive_input_select;
		ctrl_word[BIT_NEG_HI:BIT_NEG_LO]  = ctrl.negative_input_select;
	end

	// Next values for pulse, sticky flag, mask and read data
	always_comb
	begin
		next_event_pulse = edge_hit;
		next_irq_stat    = irq_stat;
		next_irq_mask    = irq_mask;
		next_rdata       = 32'h0;
		// Writes to the status address are ignored
		// Read of status clears it
		if (bus.rd && bus.addr == IRQ_STAT_ADDR)
		begin
			next_irq_stat = 1'h0;
		end
		// A new event wins over the read clear, so none is lost
		if (edge_hit)
		begin
			next_irq_stat = 1'h1;
		end
		if (bus.wr && bus.addr == IRQ_MASK_ADDR)
		begin
			next_irq_mask = bus.wdata[0];
		end
		// Read data stand for one cycle, then fall back to zero
		// Read mux; unmapped addresses read zero
		if (bus.rd)
		begin
			unique case (bus.addr)
				CTRL_ADDR:     next_rdata = ctrl_word;
				IRQ_STAT_ADDR: next_rdata = {31'h0, irq_stat};
				IRQ_MASK_ADDR: next_rdata = {31'h0, irq_mask};
				default:       next_rdata = 32'h0;
			endcase
		end
	end

	// Register pulse, status, mask and read data
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			event_pulse <= 1'h0;
			irq_stat    <= RST_IRQ;
			irq_mask    <= RST_IRQ;
			rdata       <= 32'h0;
		end
		else
		begin
			event_pulse <= next_event_pulse;
			irq_stat    <= next_irq_stat;
			irq_mask    <= next_irq_mask;
			rdata       <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign RDATA_O         = rdata;
	assign CMP_ENABLE_O    = ctrl.enable;
	// Routing is passed straight to the analog muxes
	assign ROUTE_O         = '{positive_input_select: ctrl.positive_input_select,
		negative_input_select: ctrl.negative_input_select};
	// Level is always computed; only the enable lets it out
	assign RESULT_PIN_O    = result;
	assign RESULT_PIN_OE_O = ctrl.pin_drive_enable;
	assign EVENT_PULSE_O   = event_pulse;
	// Level interrupt while the unmasked flag is set
	assign IRQ_O           = irq_stat & irq_mask;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Drive enable follows the written bit
	chk_pin_drive: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.wr && bus.addr == CTRL_ADDR) |=> (RESULT_PIN_OE_O == $past(bus.wdata[BIT_DRIVE])))
		else $error("pin enable mismatch");

	// Rise mode ignores falling edges
	chk_rise_only: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_RISE && fall) |=> !event_pulse)
		else $error("pulse on falling edge in rise mode");

	// Fall mode ignores rising edges
	chk_fall_only: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_FALL && rise) |=> !event_pulse)
		else $error("pulse on rising edge in fall mode");

	// Events off means no pulse at all
	chk_edges_off: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_NONE) |=> !event_pulse)
		else $error("pulse while events disabled");

	// Both mode catches every transition
	chk_both_edges: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_BOTH && (rise || fall)) |=> event_pulse)
		else $error("missed edge in both mode");

	// Powered core result passes the inverter
	chk_invert_path: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		ctrl.enable |-> (RESULT_PIN_O == (sync_b ^ ctrl.result_invert)))
		else $error("inversion wrong");

	// Result bit reads what the pin shows
	chk_readback_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.rd && bus.addr == CTRL_ADDR) |=> (RDATA_O[BIT_RESULT] == $past(result)))
		else $error("result readback wrong");

	// Unimplemented positions always read zero
	chk_unused_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		$past(bus.rd && bus.addr == CTRL_ADDR) |-> (RDATA_O[12:9] == 4'h0 && RDATA_O[5] == 1'h0
		&& RDATA_O[3:2] == 2'h0 && RDATA_O[31:16] == 16'h0))
		else $error("unused bits not zero");

	// Fields hold their value between writes
	chk_enable_keeps: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		!(bus.wr && bus.addr == CTRL_ADDR) |=> (ctrl == $past(ctrl)))
		else $error("control changed without write");

	// Flag stays set until a status read
	chk_sticky_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		edge_hit |=> irq_stat ##1 (irq_stat || $past(bus.rd && bus.addr == IRQ_STAT_ADDR)))
		else $error("event flag lost");

	// Rise mode fires on every rising edge
	chk_rise_event: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_RISE && rise) |=> event_pulse)
		else $error("missed rising edge");

	// Fall mode fires on every falling edge
	chk_fall_event: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(ctrl.edge_event_select == EDGE_FALL && fall) |=> event_pulse)
		else $error("missed falling edge");

	// A pulse always leaves the status flag set
	chk_flag_on_event: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		event_pulse |-> irq_stat)
		else $error("pulse without status flag");

	// Unmasked event raises the interrupt line next cycle
	chk_irq_raise: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(edge_hit && irq_mask && !(bus.wr && bus.addr == IRQ_MASK_ADDR)) |=> IRQ_O)
		else $error("interrupt not raised");

	// Status read without a new event clears the flag
	chk_status_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.rd && bus.addr == IRQ_STAT_ADDR && !edge_hit) |=> !irq_stat)
		else $error("status flag not cleared");

	// Enable output follows the written bit
	chk_enable_write: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.wr && bus.addr == CTRL_ADDR) |=> (CMP_ENABLE_O == $past(bus.wdata[BIT_ENABLE])))
		else $error("enable not written");

	// Switched-off core reads low ahead of the inverter
	chk_disabled_low: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		!ctrl.enable |-> (RESULT_PIN_O == ctrl.result_invert))
		else $error("disabled core not low");

	// Positive mux select follows the written bit
	chk_posin_route: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.wr && bus.addr == CTRL_ADDR) |=> (ROUTE_O.positive_input_select == $past(bus.wdata[BIT_POSSEL])))
		else $error("positive input route wrong");

	// Negative mux select follows the written field
	chk_negin_route: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(bus.wr && bus.addr == CTRL_ADDR)
		|=> (ROUTE_O.negative_input_select == $past(bus.wdata[BIT_NEG_HI:BIT_NEG_LO])))
		else $error("negative input route wrong");

endmodule

`default_nettype wire
